/* File: src/ltw_consts.svh */
// Constants for the write-only display target front end
`ifndef LTW_CONSTS_SVH
`define LTW_CONSTS_SVH

// Fixed upper six bits of the target address byte
`define LTW_ADDR_FIXED      6'h1c
`define LTW_ADDR_HI_BIT     7
`define LTW_ADDR_LO_BIT     2
// Address byte field positions
`define LTW_SEL_BIT         1
`define LTW_RW_BIT          0
// Command byte continuation flag position
`define LTW_CONT_BIT        7
// Bits per byte and the index of the acknowledge clock
`define LTW_BITS_PER_BYTE   4'h8
`define LTW_LAST_DATA_BIT   4'h7
`define LTW_ACK_SLOT        4'h8
// Idle level of the bus lines (also their synchroniser reset), reset value of the strap synchroniser
`define LTW_LINE_IDLE       2'h3
`define LTW_STRAP_RST       3'h0
// Width of the received-byte status counter
`define LTW_CNT_W           16

`endif

/* File: src/ltw_pkg.sv */
// Types shared by the target front end
package ltw_pkg;

    typedef enum logic [4:0] {
        LTW_IDLE   = 5'b00001,
        LTW_ADDR   = 5'b00010,
        LTW_CMD    = 5'b00100,
        LTW_DATA   = 5'b01000,
        LTW_IGNORE = 5'b10000
    } ltw_state_t;

    typedef logic [7:0] ltw_byte_t;

endpackage

/* File: src/ltw_line_if.sv */
// Line events carried from the condition detector to the receiver
`timescale 1ns/1ns
interface ltw_line_if;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic sda_level;

    modport det (
        output scl_rise,
        output scl_fall,
        output start_cond,
        output stop_cond,
        output sda_level
    );

    modport rx (
        input  scl_rise,
        input  scl_fall,
        input  start_cond,
        input  stop_cond,
        input  sda_level
    );
endinterface

/* File: src/ltw_sync2.sv */
// Two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ns
module ltw_sync2 #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta <= RST_VAL;
            q    <= RST_VAL;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

/* File: src/ltw_cond_detect.sv */
// Finds clock edges and START/STOP on the synchronised bus lines
`timescale 1ns/1ns
module ltw_cond_detect
    import ltw_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic scl_s,
    input  wire logic sda_s,
    ltw_line_if.det   ev
);
    logic scl_d;
    logic sda_d;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // SDA moving while SCL stays high is a condition, never a bit
    assign ev.scl_rise   = scl_s & ~scl_d;
    assign ev.scl_fall   = ~scl_s & scl_d;
    assign ev.start_cond = scl_s & scl_d & sda_d & ~sda_s;
    assign ev.stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
    assign ev.sda_level  = sda_s;
endmodule

/* File: src/ltw_target.sv */
// Write-only bus target: address match, command split, gated data ack
`timescale 1ns/1ns
`include "ltw_consts.svh"

module ltw_target
    import ltw_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    output logic                      sda_out,
    output logic                      sda_oe,
    input  wire logic                 target_addr_select_strap,
    input  wire logic                 hw_subaddr_pin_low,
    input  wire logic                 hw_subaddr_pin_high,
    input  wire logic [1:0]           cur_subaddr,
    output ltw_byte_t                 cmd_byte,
    output logic                      cmd_valid,
    output logic                      cmd_last,
    output ltw_byte_t                 data_byte,
    output logic                      data_valid,
    output logic                      data_mine,
    output logic                      bus_busy,
    output logic                      selected,
    output logic                      in_data_phase,
    output logic                      abort_pulse,
    output logic [`LTW_CNT_W-1:0]     rx_byte_count
);
    ltw_line_if bus ();

    logic [1:0]  line_s;
    logic [2:0]  strap_s;
    ltw_state_t  state;
    ltw_state_t  next_state;
    logic [3:0]  bit_cnt;
    logic [6:0]  shift;
    ltw_byte_t   next_byte;
    logic        receiving;
    logic        byte_done;
    logic        addr_match;
    logic        sub_match;
    logic        want_ack;
    logic        ack_pending;
    logic        ack_drive;
    logic [1:0]  hw_subaddr;

    // Bus lines and straps come from pins
    ltw_sync2 #(
        .W       (2),
        .RST_VAL (`LTW_LINE_IDLE)
    ) u_line_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .d       ({scl_in, sda_in}),
        .q       (line_s)
    );

    // Straps are static but still cross in through two flops
    ltw_sync2 #(
        .W       (3),
        .RST_VAL (`LTW_STRAP_RST)
    ) u_strap_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .d       ({target_addr_select_strap, hw_subaddr_pin_high, hw_subaddr_pin_low}),
        .q       (strap_s)
    );

    ltw_cond_detect u_det (
        .ref_clk (ref_clk),
        .rst     (rst),
        .scl_s   (line_s[1]),
        .sda_s   (line_s[0]),
        .ev      (bus)
    );

    assign hw_subaddr = strap_s[1:0];

    // Byte assembly decode
    assign receiving  = (state == LTW_ADDR) || (state == LTW_CMD) || (state == LTW_DATA);
    assign byte_done  = receiving && bus.scl_rise && (bit_cnt == `LTW_LAST_DATA_BIT);
    assign next_byte  = {shift, bus.sda_level};

    assign addr_match = (next_byte[`LTW_ADDR_HI_BIT:`LTW_ADDR_LO_BIT] == `LTW_ADDR_FIXED)
                      && (next_byte[`LTW_SEL_BIT] == strap_s[2])
                      && (next_byte[`LTW_RW_BIT] == 1'b0);
    assign sub_match  = (hw_subaddr == cur_subaddr);

    // Selection joins address, command progress and subaddress
    always_comb begin
        want_ack = 1'b0;
        case (state)
            LTW_ADDR: want_ack = addr_match;
            LTW_CMD:  want_ack = 1'b1;
            LTW_DATA: want_ack = sub_match;
            default:  want_ack = 1'b0;
        endcase
    end

    // Phase sequencing
    always_comb begin
        next_state = state;
        case (state)
            LTW_IDLE: begin
                next_state = LTW_IDLE;
            end
            LTW_ADDR: begin
                if (byte_done) begin
                    next_state = addr_match ? LTW_CMD : LTW_IGNORE;
                end
            end
            LTW_CMD: begin
                if (byte_done && !next_byte[`LTW_CONT_BIT]) begin
                    next_state = LTW_DATA;
                end
            end
            LTW_DATA: begin
                next_state = LTW_DATA;
            end
            LTW_IGNORE: begin
                next_state = LTW_IGNORE;
            end
            default: begin
                next_state = LTW_IDLE;
            end
        endcase
        // Conditions override whatever the byte logic wants
        if (bus.start_cond) begin
            next_state = LTW_ADDR;
        end else if (bus.stop_cond) begin
            next_state = LTW_IDLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= LTW_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Bit counter and shifter; the ack clock is slot eight
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bit_cnt <= 4'h0;
            shift   <= 7'h00;
        end else if (bus.start_cond || bus.stop_cond) begin
            bit_cnt <= 4'h0;
            shift   <= 7'h00;
        end else if (receiving && bus.scl_rise) begin
            if (bit_cnt == `LTW_ACK_SLOT) begin
                bit_cnt <= 4'h0;
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
                shift   <= next_byte[6:0];
            end
        end
    end

    // Ack: pull low from the fall after bit 8 to the fall after the ack clock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack_pending <= 1'b0;
            ack_drive   <= 1'b0;
        end else if (bus.start_cond || bus.stop_cond) begin
            ack_pending <= 1'b0;
            ack_drive   <= 1'b0;
        end else if (byte_done) begin
            ack_pending <= want_ack;
        end else if (bus.scl_fall) begin
            if (ack_drive) begin
                ack_drive <= 1'b0;
            end else if (ack_pending) begin
                ack_drive   <= 1'b1;
                ack_pending <= 1'b0;
            end
        end
    end

    // Open drain: only ever a low, never a driven high
    assign sda_out = 1'b0;
    assign sda_oe  = ack_drive;

    // Command bytes to the decoder
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmd_byte  <= 8'h00;
            cmd_valid <= 1'b0;
            cmd_last  <= 1'b0;
        end else begin
            cmd_valid <= 1'b0;
            if (byte_done && state == LTW_CMD) begin
                cmd_byte  <= next_byte;
                cmd_valid <= 1'b1;
                cmd_last  <= ~next_byte[`LTW_CONT_BIT];
            end
        end
    end

    // Display bytes; data_valid advances the pointers on every device
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_byte  <= 8'h00;
            data_valid <= 1'b0;
            data_mine  <= 1'b0;
        end else begin
            data_valid <= 1'b0;
            if (byte_done && state == LTW_DATA) begin
                data_byte  <= next_byte;
                data_valid <= 1'b1;
                data_mine  <= sub_match;
            end
        end
    end

    // Status
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_busy <= 1'b0;
        end else if (bus.start_cond) begin
            bus_busy <= 1'b1;
        end else if (bus.stop_cond) begin
            bus_busy <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            selected      <= 1'b0;
            in_data_phase <= 1'b0;
        end else begin
            selected      <= (next_state == LTW_CMD) || (next_state == LTW_DATA);
            in_data_phase <= (next_state == LTW_DATA);
        end
    end

    // Flags a condition that cut a byte short
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            abort_pulse <= 1'b0;
        end else begin
            // First clock high after a byte may carry the condition itself
            abort_pulse <= (bus.start_cond || bus.stop_cond) && receiving
                           && (bit_cnt > 4'h1);
        end
    end

    // Wraps freely; the transfer length itself is unbounded
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_byte_count <= '0;
        end else if (byte_done && state != LTW_ADDR) begin
            rx_byte_count <= rx_byte_count + `LTW_CNT_W'(1);
        end
    end
endmodule

/* File: testbench/ltw_target_checker.sv */
// Port assertions for the bus target
`timescale 1ns/1ns
module ltw_target_checker
    import ltw_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       hw_subaddr_pin_low,
    input wire logic       hw_subaddr_pin_high,
    input wire logic [1:0] cur_subaddr,
    input wire ltw_byte_t  cmd_byte,
    input wire logic       cmd_valid,
    input wire logic       cmd_last,
    input wire logic       data_valid,
    input wire logic       data_mine,
    input wire logic       bus_busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    drive_low_a: assert property (sda_oe |-> !sda_out) else $error("sda high");
    ack_busy_a: assert property (sda_oe |-> bus_busy) else $error("ack idle");
    ack_hold_a: assert property (sda_oe && scl_in |=> sda_oe) else $error("ack hold");
    ack_release_a: assert property (sda_oe && $fell(scl_in) |-> ##[1:5] !sda_oe)
        else $error("ack release");
    cmd_flag_a: assert property (cmd_valid |-> cmd_last == !cmd_byte[7])
        else $error("cmd flag");
    data_gate_a: assert property (data_valid |->
        data_mine == ({hw_subaddr_pin_high, hw_subaddr_pin_low} == cur_subaddr))
        else $error("data gate");
    data_ack_a: assert property (data_valid && data_mine |-> ##[4:14] sda_oe)
        else $error("data ack");
    data_nack_a: assert property (data_valid && !data_mine |-> ##6 !sda_oe [*8])
        else $error("data nack");
    start_seen_a: assert property (
        !bus_busy && scl_in && $fell(sda_in) |-> ##[1:5] bus_busy) else $error("start");
    stop_seen_a: assert property (
        bus_busy && scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:5] !bus_busy)
        else $error("stop");
endmodule

/* File: testbench/ltw_ctrl_model.sv */
// Bus controller model: drives SCL and its side of SDA
`timescale 1ns/1ns
module ltw_ctrl_model (
    output logic      scl,
    output logic      sda,
    input  wire logic sda_bus
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic start();
        sda = 1'b1;
        #40 scl = 1'b1;
        #40 sda = 1'b0;
        #40 scl = 1'b0;
    endtask
    task automatic stop();
        sda = 1'b0;
        #40 scl = 1'b1;
        #40 sda = 1'b1;
        #40;
    endtask
    // Data moves only while SCL is low; n below 8 leaves a partial byte
    task automatic send(input logic [7:0] b, input int n, output logic ack);
        ack = 1'b0;
        for (int i = 7; i > 7 - n; i--) begin
            sda = b[i];
            #40 scl = 1'b1;
            #80 scl = 1'b0;
            #40;
        end
        if (n == 8) begin
            sda = 1'b1;
            #40 scl = 1'b1;
            #40 ack = !sda_bus;
            #40 scl = 1'b0;
            #40;
        end
    endtask
endmodule

/* File: testbench/tb_ltw_target.sv */
// Testbench for the write-only bus target
`timescale 1ns/1ns
module tb_ltw_target;
    import ltw_pkg::*;
    logic       ref_clk, rst, scl_c, sda_c, strap, sub_lo, sub_hi, sda_out, sda_oe;
    logic       cmd_valid, cmd_last, data_valid, data_mine, bus_busy, abort_pulse;
    logic       selected, in_data_phase;
    logic [1:0] cur_sub;
    ltw_byte_t  cmd_byte, data_byte;
    logic [15:0] rx_byte_count;
    logic [8:0] cq[$];
    logic [8:0] dq[$];
    int         n_errors, n_tests, n_abort;
    // Wired-and with the pull-up: released means high
    wire        sda_w = sda_c & ~(sda_oe & ~sda_out);

    ltw_target ltw_target_inst (.ref_clk(ref_clk), .rst(rst), .scl_in(scl_c),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
        .target_addr_select_strap(strap), .hw_subaddr_pin_low(sub_lo),
        .hw_subaddr_pin_high(sub_hi), .cur_subaddr(cur_sub), .cmd_byte(cmd_byte),
        .cmd_valid(cmd_valid), .cmd_last(cmd_last), .data_byte(data_byte),
        .data_valid(data_valid), .data_mine(data_mine), .bus_busy(bus_busy),
        .selected(selected), .in_data_phase(in_data_phase), .abort_pulse(abort_pulse),
        .rx_byte_count(rx_byte_count));
    ltw_ctrl_model ltw_ctrl_model_inst (.scl(scl_c), .sda(sda_c), .sda_bus(sda_w));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (cmd_valid) cq.push_back({cmd_last, cmd_byte});
        if (data_valid) dq.push_back({data_mine, data_byte});
        if (abort_pulse) n_abort++;
    end

    task automatic chk16(input logic [15:0] g, input logic [15:0] e, input string m);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic chk1(input logic g, input logic e, input string m);
        chk16({15'h0000, g}, {15'h0000, e}, m);
    endtask
    task automatic xb(input logic [7:0] b, input logic e, input string m);
        logic a;
        ltw_ctrl_model_inst.send(b, 8, a);
        chk1(a, e, m);
    endtask
    // Straps are synchronised, so give them a few edges to settle
    task automatic pins(input logic s, input logic [1:0] hw, input logic [1:0] cur);
        @(negedge ref_clk);
        strap = s;
        {sub_hi, sub_lo} = hw;
        cur_sub = cur;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic t_basic();
        pins(1'b0, 2'h0, 2'h0);
        ltw_ctrl_model_inst.start();
        xb(8'h70, 1'b1, "addr");
        xb(8'he0, 1'b1, "cmd");
        chk1(in_data_phase, 1'b0, "cmd phase");
        xb(8'h4c, 1'b1, "last cmd");
        chk1(in_data_phase, 1'b1, "data phase");
        chk1(selected, 1'b1, "selected");
        xb(8'ha5, 1'b1, "data");
        pins(1'b0, 2'h0, 2'h1);
        xb(8'h3c, 1'b0, "data other");
        ltw_ctrl_model_inst.stop();
        repeat (8) @(negedge ref_clk);
        chk1(bus_busy, 1'b0, "busy");
        chk1(selected, 1'b0, "deselected");
        chk16(16'(n_abort), 16'h0000, "no abort");
        chk16({7'h00, cq.pop_front()}, 16'h00e0, "cmd 1");
        chk16({7'h00, cq.pop_front()}, 16'h014c, "cmd 2");
        chk16({7'h00, dq.pop_front()}, 16'h01a5, "data 1");
        chk16({7'h00, dq.pop_front()}, 16'h003c, "data 2");
        chk16(rx_byte_count, 16'h0004, "count");
        $display("test basic done");
    endtask
    task automatic t_mismatch();
        logic [7:0] bad[3] = '{8'h72, 8'h71, 8'h60};
        foreach (bad[i]) begin
            ltw_ctrl_model_inst.start();
            xb(bad[i], 1'b0, "bad addr");
            chk1(selected, 1'b0, "not selected");
            xb(8'h80, 1'b0, "ignored");
            xb(8'h00, 1'b0, "ignored");
            ltw_ctrl_model_inst.stop();
        end
        chk16(rx_byte_count, 16'h0004, "count");
        chk1(cq.size() == 0 && dq.size() == 0, 1'b1, "strobes");
        $display("test mismatch done");
    endtask
    task automatic t_strap();
        pins(1'b1, 2'h2, 2'h0);
        ltw_ctrl_model_inst.start();
        xb(8'h72, 1'b1, "addr sel");
        xb(8'h00, 1'b1, "cmd");
        pins(1'b1, 2'h2, 2'h2);
        xb(8'h5a, 1'b1, "data sub");
        ltw_ctrl_model_inst.start();
        xb(8'h70, 1'b0, "restart addr");
        xb(8'h00, 1'b0, "ignored");
        ltw_ctrl_model_inst.stop();
        chk16({7'h00, cq.pop_front()}, 16'h0100, "cmd");
        chk16({7'h00, dq.pop_front()}, 16'h015a, "data");
        chk16(rx_byte_count, 16'h0006, "count");
        $display("test strap done");
    endtask
    task automatic t_abort();
        logic a;
        pins(1'b0, 2'h0, 2'h0);
        ltw_ctrl_model_inst.start();
        xb(8'h70, 1'b1, "addr");
        ltw_ctrl_model_inst.send(8'hff, 4, a);
        ltw_ctrl_model_inst.start();
        xb(8'h70, 1'b1, "addr again");
        xb(8'h81, 1'b1, "cmd");
        ltw_ctrl_model_inst.send(8'h00, 3, a);
        ltw_ctrl_model_inst.stop();
        repeat (8) @(negedge ref_clk);
        chk16(16'(n_abort), 16'h0002, "aborts");
        chk16({7'h00, cq.pop_front()}, 16'h0081, "cmd");
        chk1(cq.size() == 0, 1'b1, "partial");
        chk16(rx_byte_count, 16'h0007, "count");
        $display("test abort done");
    endtask
    task automatic final_report();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        {strap, sub_lo, sub_hi, cur_sub} = 5'h00;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        repeat (6) @(negedge ref_clk);
        chk16(rx_byte_count, 16'h0000, "count at reset");
        chk1(sda_oe, 1'b0, "released at reset");
        t_basic();
        t_mismatch();
        t_strap();
        t_abort();
        final_report();
    end
    // About 35 us of traffic is expected
    initial begin
        #300000;
        n_errors++;
        $display("MISMATCH %0t watchdog", $time);
        final_report();
    end
endmodule

bind ltw_target ltw_target_checker ltw_target_checker_inst (.ref_clk(ref_clk), .rst(rst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .hw_subaddr_pin_low(hw_subaddr_pin_low), .hw_subaddr_pin_high(hw_subaddr_pin_high),
    .cur_subaddr(cur_subaddr), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid),
    .cmd_last(cmd_last), .data_valid(data_valid), .data_mine(data_mine),
    .bus_busy(bus_busy));
